// file: pkg/ebpt_defs.svh
// register offsets, field positions, reset values and phase widths
`ifndef EBPT_DEFS_SVH
`define EBPT_DEFS_SVH

`define EBPT_OFF_MODE0 8'h00
`define EBPT_OFF_MODE1 8'h04
`define EBPT_OFF_ADDR 8'h08
`define EBPT_OFF_WDATA 8'h0C
`define EBPT_OFF_CTRL 8'h10
`define EBPT_OFF_STAT 8'h14

`define EBPT_M0_RDY_POL 15
`define EBPT_M0_RDY_OFF 14
`define EBPT_M0_LATCH_OFF 13
`define EBPT_M0_UPPER_OFF 12
`define EBPT_M0_STYLE 11
`define EBPT_M0_PINS_OFF 10
`define EBPT_M0_FOLLOWER 9
`define EBPT_M0_ARB_ON 8
`define EBPT_M0_SEL_HI 7
`define EBPT_M0_SEL_LO 4
`define EBPT_M0_SEG_HI 3
`define EBPT_M0_SEG_LO 0
`define EBPT_MODE0_RESET 16'h0000

`define EBPT_M1_DATA_HI_OFF 6
`define EBPT_M1_APD_HI 4
`define EBPT_M1_APD_LO 0
`define EBPT_MODE1_RESET 16'h0000
`define EBPT_MODE1_MASK 16'h005F
`define EBPT_APD_ALL_OFF 5'h1F

`define EBPT_CTRL_GO 0
`define EBPT_CTRL_WRITE 1
`define EBPT_CTRL_LO 2
`define EBPT_CTRL_HI 3
`define EBPT_STAT_BUSY 0
`define EBPT_STAT_RD_LO 16

`define EBPT_T_A_HI 1
`define EBPT_T_A_LO 0
`define EBPT_T_B 2
`define EBPT_T_C_HI 4
`define EBPT_T_C_LO 3
`define EBPT_T_D 5
`define EBPT_T_E_HI 10
`define EBPT_T_E_LO 6
`define EBPT_T_RF_HI 12
`define EBPT_T_RF_LO 11
`define EBPT_T_WF_HI 14
`define EBPT_T_WF_LO 13

`define EBPT_PH_DONE 3'h6
`define EBPT_SEL_MAX 4'h8

`endif

// file: pkg/ebpt_pkg.sv
// types of the external bus phase sequencer
package ebpt_pkg;

    typedef enum logic [6:0] {
        EBPT_IDLE = 7'h01,
        EBPT_A = 7'h02,
        EBPT_B = 7'h04,
        EBPT_C = 7'h08,
        EBPT_D = 7'h10,
        EBPT_E = 7'h20,
        EBPT_F = 7'h40
    } ebpt_phase_t;

    typedef struct packed {
        ebpt_phase_t phase;
        logic [2:0] idx;
        logic [5:0] cnt;
        logic [15:0] mode0;
        logic [15:0] mode1;
        logic locked;
        logic [23:0] req_addr;
        logic [15:0] req_wdata;
        logic req_wr;
        logic req_lo;
        logic req_hi;
        logic go;
        logic [15:0] rdata;
        logic [2:0] cur_cs;
        logic [2:0] last_cs;
        logic [1:0] last_pha;
        logic have_last;
        logic [1:0] idle_cnt;
        logic [1:0] a_len;
        logic [14:0] tim;
        logic split;
        logic mux;
        logic rdy_en;
        logic ref_d;
        logic [7:0] sel_mask;
        logic [7:0] seg_mask;
        logic wb_ack;
        logic [31:0] wb_dat;
        logic ale;
        logic ale_oe;
        logic rd_n;
        logic ctl_oe;
        logic lo_n;
        logic hi_n;
        logic hi_oe;
        logic [23:0] addr_out;
        logic addr_lo_oe;
        logic [7:0] addr_seg_oe;
        logic [15:0] ad_out;
        logic ad_lo_oe;
        logic ad_hi_oe;
        logic [7:0] cs_n;
        logic [7:0] cs_oe;
        logic grant_oe;
        logic claim_oe;
    } ebpt_state_t;

    typedef struct packed {
        logic [17:0] s1;
        logic [17:0] s2;
    } ebpt_sync_t;

endpackage

// file: logic/ebpt_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ebpt_sync #(
    parameter int W = 18
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    ebpt_pkg::ebpt_sync_t r;
    ebpt_pkg::ebpt_sync_t n;

    // first stage feeds only the second stage
    always_comb begin
        n = r;
        n.s1 = '0;
        n.s1[W-1:0] = d;
        n.s2 = r.s1;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign q = r.s2[W-1:0];
endmodule

// file: logic/ebpt_top.sv
// external bus phase sequencer with mode registers and wishbone slave
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "ebpt_defs.svh"

// Summary of operation
// - reads and writes, multiplexed or demultiplexed
// - general strobe: upper enable and bit 0
// - split style: per-byte strobes, bit 0 free
// - turnaround phase only when chip select changes
// - turnaround length from the finished select
// - turnaround drives next address and latch
// - idle clocks shorten the turnaround phase
// - latch phase 1-2 clocks, address out
// - delay phase 0-3 clocks, latch low
// - data phase: release address, drive write data
// - command phase 1-32, capture read last
// - ready stretches command phase until asserted
// - hold phase 0-3, separate read/write length
// - select 0 takes all unclaimed accesses
// - init lock blocks configuration writes
// - bit 15 sets ready polarity
// - pin off bits release their pins; upper off releases the high strobe only in general strobe style
// - strobe style bit, latched per access
// - arbitration pins enable and follower mode
// - select pin count enables pins cumulatively
// - segment pin count enables A16 upward
// - upper data and address pin release
// - the phase sequencer steps on rising reference clock edges
module ebpt_top (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic init_lock_instruction,
    input wire logic [7:1] win_hit,
    input wire logic [7:0][14:0] cs_timing,
    input wire logic [7:0][1:0] cs_bus_type,
    input wire logic [7:0] cs_ready_en,
    input wire logic ref_clk,
    input wire logic ready_in,
    input wire logic [15:0] ad_in,
    output logic [15:0] ad_out,
    output logic ad_lo_oe,
    output logic ad_hi_oe,
    output logic [23:0] addr_out,
    output logic addr_lo_oe,
    output logic [7:0] addr_seg_oe,
    output logic ale,
    output logic ale_oe,
    output logic rd_n,
    output logic ctl_oe,
    output logic low_byte_store_strobe_n,
    output logic high_byte_store_strobe_n,
    output logic high_strobe_oe,
    output logic [7:0] cs_n,
    output logic [7:0] cs_oe,
    output logic bus_grant_ack_n,
    output logic bus_grant_ack_oe,
    output logic bus_claim_n,
    output logic bus_claim_oe,
    output logic follower_mode
);
    ebpt_pkg::ebpt_state_t r;
    ebpt_pkg::ebpt_state_t n;
    logic [17:0] sync_q;
    logic ref_s;
    logic ready_s;
    logic [15:0] ad_s;
    logic tick;
    logic wr_hit;
    logic rdy_act;
    logic [2:0] new_cs;
    logic [5:0] len;
    logic a0;
    logic in_e;
    logic in_abc;

    ebpt_sync #(.W(18)) u_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .d({ref_clk, ready_in, ad_in}),
        .q(sync_q)
    );
    assign ref_s = sync_q[17];
    assign ready_s = sync_q[16];
    assign ad_s = sync_q[15:0];
    assign tick = ref_s & ~r.ref_d;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [5:0] ebpt_len(input logic [2:0] i,
        input logic [14:0] t, input logic wr, input logic [1:0] a);
        logic [5:0] l;
        l = 6'h00;
        unique case (i)
            3'h0: l = {4'h0, a};
            3'h1: l = {5'h00, t[`EBPT_T_B]} + 6'h01;
            3'h2: l = {4'h0, t[`EBPT_T_C_HI:`EBPT_T_C_LO]};
            3'h3: l = {5'h00, t[`EBPT_T_D]};
            3'h4: l = {1'b0, t[`EBPT_T_E_HI:`EBPT_T_E_LO]} + 6'h01;
            3'h5: begin
                l = wr ? {4'h0, t[`EBPT_T_WF_HI:`EBPT_T_WF_LO]}
                       : {4'h0, t[`EBPT_T_RF_HI:`EBPT_T_RF_LO]};
            end
            default: l = 6'h00;
        endcase
        return l;
    endfunction

    // first phase at or after from with a nonzero length
    function automatic logic [2:0] ebpt_next(input logic [2:0] from,
        input logic [14:0] t, input logic wr, input logic [1:0] a);
        logic [2:0] res;
        res = `EBPT_PH_DONE;
        for (int i = 5; i >= 0; i--) begin
            if (3'(i) >= from && ebpt_len(3'(i), t, wr, a) != 6'h00) begin
                res = 3'(i);
            end
        end
        return res;
    endfunction

    function automatic ebpt_pkg::ebpt_phase_t ebpt_ph(input logic [2:0] i);
        ebpt_pkg::ebpt_phase_t p;
        unique case (i)
            3'h0: p = ebpt_pkg::EBPT_A;
            3'h1: p = ebpt_pkg::EBPT_B;
            3'h2: p = ebpt_pkg::EBPT_C;
            3'h3: p = ebpt_pkg::EBPT_D;
            3'h4: p = ebpt_pkg::EBPT_E;
            3'h5: p = ebpt_pkg::EBPT_F;
            default: p = ebpt_pkg::EBPT_IDLE;
        endcase
        return p;
    endfunction

    function automatic logic [7:0] ebpt_cnt_mask(input logic [3:0] c);
        return 8'hFF >> (`EBPT_SEL_MAX - c);
    endfunction

    function automatic logic [15:0] ebpt_merge(input logic [15:0] old,
        input logic [15:0] d, input logic [1:0] sel);
        return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    // lowest claiming window wins, none falls to select 0
    function automatic logic [2:0] ebpt_pick(input logic [7:1] hit);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 7; i >= 1; i--) begin
            if (hit[i]) begin
                c = 3'(i);
            end
        end
        return c;
    endfunction

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        n = r;
        wr_hit = 1'b0;
        rdy_act = 1'b0;
        new_cs = 3'h0;
        len = 6'h00;
        a0 = 1'b0;
        in_e = 1'b0;
        in_abc = 1'b0;
        n.ref_d = ref_s;
        n.wb_ack = wb_cyc_i & wb_stb_i & ~r.wb_ack;
        n.wb_dat = 32'h0000_0000;
        if (n.wb_ack && !wb_we_i) begin
            unique case (wb_adr_i)
                `EBPT_OFF_MODE0: n.wb_dat = {16'h0000, r.mode0};
                `EBPT_OFF_MODE1: n.wb_dat = {16'h0000, r.mode1};
                `EBPT_OFF_ADDR: n.wb_dat = {8'h00, r.req_addr};
                `EBPT_OFF_WDATA: n.wb_dat = {16'h0000, r.req_wdata};
                `EBPT_OFF_CTRL: n.wb_dat = {28'h000_0000, r.req_hi,
                    r.req_lo, r.req_wr, r.go};
                `EBPT_OFF_STAT: n.wb_dat = {r.rdata, 15'h0000,
                    r.go | (r.phase != ebpt_pkg::EBPT_IDLE)};
                default: n.wb_dat = 32'h0000_0000;
            endcase
        end
        wr_hit = n.wb_ack & wb_we_i;
        if (init_lock_instruction) begin
            n.locked = 1'b1;
        end
        if (wr_hit && !r.locked) begin
            if (wb_adr_i == `EBPT_OFF_MODE0) begin
                n.mode0 = ebpt_merge(r.mode0, wb_dat_i[15:0], wb_sel_i[1:0]);
            end
            if (wb_adr_i == `EBPT_OFF_MODE1) begin
                n.mode1 = ebpt_merge(r.mode1, wb_dat_i[15:0], wb_sel_i[1:0])
                    & `EBPT_MODE1_MASK;
            end
        end
        // request registers are frozen while an access is pending
        if (wr_hit && r.phase == ebpt_pkg::EBPT_IDLE && !r.go) begin
            if (wb_adr_i == `EBPT_OFF_ADDR) begin
                n.req_addr = {wb_sel_i[2] ? wb_dat_i[23:16] : r.req_addr[23:16],
                    ebpt_merge(r.req_addr[15:0], wb_dat_i[15:0],
                    wb_sel_i[1:0])};
            end
            if (wb_adr_i == `EBPT_OFF_WDATA) begin
                n.req_wdata = ebpt_merge(r.req_wdata, wb_dat_i[15:0],
                    wb_sel_i[1:0]);
            end
            if (wb_adr_i == `EBPT_OFF_CTRL && wb_sel_i[0]) begin
                n.go = wb_dat_i[`EBPT_CTRL_GO];
                n.req_wr = wb_dat_i[`EBPT_CTRL_WRITE];
                n.req_lo = wb_dat_i[`EBPT_CTRL_LO];
                n.req_hi = wb_dat_i[`EBPT_CTRL_HI];
            end
        end
        // reserved counts keep the previous pin set
        if (r.mode0[`EBPT_M0_SEL_HI:`EBPT_M0_SEL_LO] <= `EBPT_SEL_MAX) begin
            n.sel_mask = ebpt_cnt_mask(
                r.mode0[`EBPT_M0_SEL_HI:`EBPT_M0_SEL_LO]);
        end
        if (r.mode0[`EBPT_M0_SEG_HI:`EBPT_M0_SEG_LO] <= `EBPT_SEL_MAX) begin
            n.seg_mask = ebpt_cnt_mask(
                r.mode0[`EBPT_M0_SEG_HI:`EBPT_M0_SEG_LO]);
        end
        rdy_act = r.mode0[`EBPT_M0_RDY_POL] ? ready_s : ~ready_s;

        // --------------------------------------------------------------
        // phase sequencer, one step per rising reference clock edge
        // --------------------------------------------------------------
        if (tick) begin
            if (r.phase == ebpt_pkg::EBPT_IDLE) begin
                if (r.go) begin
                    new_cs = ebpt_pick(win_hit);
                    n.go = 1'b0;
                    n.cur_cs = new_cs;
                    n.tim = cs_timing[new_cs];
                    n.mux = cs_bus_type[new_cs][0];
                    n.rdy_en = cs_ready_en[new_cs]
                        & ~r.mode0[`EBPT_M0_RDY_OFF];
                    n.split = r.mode0[`EBPT_M0_STYLE];
                    n.a_len = 2'h0;
                    if (r.have_last && new_cs != r.last_cs) begin
                        n.a_len = (r.last_pha > r.idle_cnt) ?
                            r.last_pha - r.idle_cnt : 2'h0;
                    end
                    n.idx = ebpt_next(3'h0, n.tim, r.req_wr, n.a_len);
                    len = ebpt_len(n.idx, n.tim, r.req_wr, n.a_len);
                    n.cnt = len - 6'h01;
                    n.phase = ebpt_ph(n.idx);
                end else if (r.idle_cnt != 2'h3) begin
                    n.idle_cnt = r.idle_cnt + 2'h1;
                end
            end else if (r.cnt != 6'h00) begin
                n.cnt = r.cnt - 6'h01;
            end else if (r.phase == ebpt_pkg::EBPT_E && r.rdy_en && !rdy_act)
            begin
                n.cnt = 6'h00;
            end else begin
                if (r.phase == ebpt_pkg::EBPT_E && !r.req_wr) begin
                    n.rdata = ad_s;
                end
                n.idx = ebpt_next(r.idx + 3'h1, r.tim, r.req_wr, r.a_len);
                len = ebpt_len(n.idx, r.tim, r.req_wr, r.a_len);
                n.cnt = len - 6'h01;
                n.phase = ebpt_ph(n.idx);
                if (n.idx == `EBPT_PH_DONE) begin
                    n.cnt = 6'h00;
                    n.last_cs = r.cur_cs;
                    n.last_pha = r.tim[`EBPT_T_A_HI:`EBPT_T_A_LO];
                    n.have_last = 1'b1;
                    n.idle_cnt = 2'h0;
                end
            end
        end

        // --------------------------------------------------------------
        // pins, computed from the next state so they leave a flop
        // --------------------------------------------------------------
        in_e = n.phase == ebpt_pkg::EBPT_E;
        in_abc = n.phase == ebpt_pkg::EBPT_A || n.phase == ebpt_pkg::EBPT_B
            || n.phase == ebpt_pkg::EBPT_C;
        a0 = n.split ? n.req_addr[0] : (n.req_hi & ~n.req_lo);
        n.addr_out = {n.req_addr[23:1], a0};
        n.ale = n.phase == ebpt_pkg::EBPT_A || n.phase == ebpt_pkg::EBPT_B;
        n.rd_n = ~(in_e & ~n.req_wr);
        if (n.split) begin
            n.lo_n = ~(in_e & n.req_wr & n.req_lo);
            n.hi_n = ~(in_e & n.req_wr & n.req_hi);
        end else begin
            n.lo_n = ~(in_e & n.req_wr);
            n.hi_n = ~(n.req_hi & (n.phase != ebpt_pkg::EBPT_IDLE));
        end
        n.ad_out = (n.mux && in_abc) ? n.addr_out[15:0] : n.req_wdata;
        n.ad_lo_oe = ~r.mode0[`EBPT_M0_PINS_OFF] & ((n.mux & in_abc)
            | (n.req_wr & (n.phase == ebpt_pkg::EBPT_D || in_e
            || n.phase == ebpt_pkg::EBPT_F)));
        n.ad_hi_oe = n.ad_lo_oe & ~r.mode1[`EBPT_M1_DATA_HI_OFF];
        n.addr_lo_oe = ~r.mode0[`EBPT_M0_PINS_OFF] & (r.mode1[`EBPT_M1_APD_HI:
            `EBPT_M1_APD_LO] != `EBPT_APD_ALL_OFF);
        n.cs_n = 8'hFF;
        if (n.phase != ebpt_pkg::EBPT_IDLE) begin
            n.cs_n[n.cur_cs] = 1'b0;
        end
        // pin release
        n.ale_oe = ~r.mode0[`EBPT_M0_PINS_OFF] & ~r.mode0[`EBPT_M0_LATCH_OFF];
        n.ctl_oe = ~r.mode0[`EBPT_M0_PINS_OFF];
        n.hi_oe = ~r.mode0[`EBPT_M0_PINS_OFF]
            & (n.split | ~r.mode0[`EBPT_M0_UPPER_OFF]);
        n.addr_seg_oe = r.mode0[`EBPT_M0_PINS_OFF] ? 8'h00 : n.seg_mask;
        n.cs_oe = r.mode0[`EBPT_M0_PINS_OFF] ? 8'h00 : n.sel_mask;
        n.claim_oe = r.mode0[`EBPT_M0_ARB_ON];
        n.grant_oe = r.mode0[`EBPT_M0_ARB_ON] & ~r.mode0[`EBPT_M0_FOLLOWER];
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            r <= '0;
            r.phase <= ebpt_pkg::EBPT_IDLE;
            r.mode0 <= `EBPT_MODE0_RESET;
            r.mode1 <= `EBPT_MODE1_RESET;
            r.rd_n <= 1'b1;
            r.lo_n <= 1'b1;
            r.hi_n <= 1'b1;
            r.cs_n <= 8'hFF;
        end else begin
            r <= n;
        end
    end

    assign wb_dat_o = r.wb_dat;
    assign wb_ack_o = r.wb_ack;
    assign ad_out = r.ad_out;
    assign ad_lo_oe = r.ad_lo_oe;
    assign ad_hi_oe = r.ad_hi_oe;
    assign addr_out = r.addr_out;
    assign addr_lo_oe = r.addr_lo_oe;
    assign addr_seg_oe = r.addr_seg_oe;
    assign ale = r.ale;
    assign ale_oe = r.ale_oe;
    assign rd_n = r.rd_n;
    assign ctl_oe = r.ctl_oe;
    assign low_byte_store_strobe_n = r.lo_n;
    assign high_byte_store_strobe_n = r.hi_n;
    assign high_strobe_oe = r.hi_oe;
    assign cs_n = r.cs_n;
    assign cs_oe = r.cs_oe;
    assign bus_grant_ack_n = 1'b1;
    assign bus_grant_ack_oe = r.grant_oe;
    assign bus_claim_n = 1'b1;
    assign bus_claim_oe = r.claim_oe;
    assign follower_mode = r.mode0[`EBPT_M0_FOLLOWER];

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    a_cmd_in_e: assert property (@(posedge clk_sys) disable iff (srst)
        (!r.rd_n || !r.lo_n) |-> r.phase == ebpt_pkg::EBPT_E)
        else $error("command strobe outside command phase");
    a_latch_ab: assert property (@(posedge clk_sys) disable iff (srst)
        r.ale == (r.phase == ebpt_pkg::EBPT_A || r.phase == ebpt_pkg::EBPT_B))
        else $error("latch strobe does not match phase");
    a_lock_holds: assert property (@(posedge clk_sys) disable iff (srst)
        (r.locked && wr_hit && wb_adr_i == `EBPT_OFF_MODE0) |=>
        $stable(r.mode0))
        else $error("mode register written after lock");
    a_a0_hi_only: assert property (@(posedge clk_sys) disable iff (srst)
        (r.phase == ebpt_pkg::EBPT_E && !r.split && r.req_hi && !r.req_lo)
        |-> r.addr_out[0] && !r.hi_n)
        else $error("high byte access lacks bit 0 or upper enable");
    a_split_hi: assert property (@(posedge clk_sys) disable iff (srst)
        (r.split && !r.hi_n) |-> r.req_hi && r.req_wr)
        else $error("high store strobe without high byte write");
    a_mux_release: assert property (@(posedge clk_sys) disable iff (srst)
        (r.mux && !r.req_wr && r.phase == ebpt_pkg::EBPT_D) |-> !r.ad_lo_oe)
        else $error("address still driven in release phase");
    a_ready_stall: assert property (@(posedge clk_sys) disable iff (srst)
        (tick && r.phase == ebpt_pkg::EBPT_E && r.cnt == 6'h00 && r.rdy_en
        && !rdy_act) |=> r.phase == ebpt_pkg::EBPT_E)
        else $error("command phase ended without ready");
    a_no_turn: assert property (@(posedge clk_sys) disable iff (srst)
        (tick && r.phase == ebpt_pkg::EBPT_IDLE && r.go
        && ebpt_pick(win_hit) == r.last_cs) |=> r.phase != ebpt_pkg::EBPT_A)
        else $error("turnaround inserted for the same select");
    a_wb_ack: assert property (@(posedge clk_sys) disable iff (srst)
        (wb_cyc_i && wb_stb_i && !r.wb_ack) |=> r.wb_ack ##1 !r.wb_ack)
        else $error("bus answer not a single cycle");
endmodule

// file: verification/ebpt_mem_model.sv
// far-side memory: answers reads on select 0, stretches with ready
`timescale 1ns/1ps
module ebpt_mem_model #(
    parameter logic [15:0] RD_DATA = 16'hA5C3
) (
    input wire logic clk_sys,
    input wire logic rd_n,
    input wire logic [7:0] cs_n,
    input wire logic [15:0] ad_out,
    input wire logic ad_lo_oe,
    input wire logic ready_pol,
    input wire logic [15:0] wait_cyc,
    output logic [15:0] ad_in,
    output logic ready_in
);
    logic [15:0] n_reg = 16'h0000;
    logic [15:0] last_reg = 16'h0000;
    logic sel_rd;

    assign sel_rd = !rd_n && !cs_n[0];
    always @(posedge clk_sys) begin
        n_reg <= sel_rd ? n_reg + 16'h0001 : 16'h0000;
        last_reg <= ad_in;
    end
    // ready held off for wait_cyc cycles of each read on select 0
    assign ready_in = ready_pol ~^ (sel_rd && n_reg >= wait_cyc);
    // released bus toggles every cycle so a stale value never matches;
    // read data follows the wait so an old capture cannot pass
    assign ad_in = ad_lo_oe ? ad_out
        : sel_rd ? RD_DATA ^ wait_cyc : ~last_reg;
endmodule

// file: verification/external_bus_phase_timing_test.sv
// self-checking bench for the external bus phase sequencer
`timescale 1ns/1ps
module external_bus_phase_timing_test;
    logic clk_sys = 0, srst = 1, ref_clk = 0, cyc = 0, stb = 0, we = 0;
    logic lock = 0, ale, ale_oe, rd_n, wr_lo_n, wr_hi_n, ack, ad_oe, ready;
    logic lo_seen, hi_seen, a0;
    logic rpol = 0, hso, cto, clo, gro, fol, alo;
    logic [7:0] sgo, cs_and;
    logic [7:1] hit = 7'h00;
    logic [7:0][14:0] tim = '0;
    logic [7:0] adr = 8'h00, cs_n, cs_oe;
    logic [31:0] dat = 32'h0000_0000, q, rdat;
    logic [7:0][1:0] btyp = '0;
    logic [7:0] rdy_en = 8'h00;
    logic [15:0] ad_in, ad_out, lat_ad, wait_cyc = 16'h0000;
    logic [23:0] addr_out;
    int num_errors = 0, n_checks = 0, cyc_cnt = 0, rd_len = 0;
    int ale_len = 0, lo_len = 0, cs_len = 0;

    ebpt_top u_ebpt_top (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .init_lock_instruction(lock), .win_hit(hit), .cs_timing(tim),
        .cs_bus_type(btyp), .cs_ready_en(rdy_en), .ref_clk(ref_clk),
        .ready_in(ready), .ad_in(ad_in), .ad_out(ad_out), .ad_lo_oe(ad_oe),
        .ad_hi_oe(), .addr_out(addr_out), .addr_lo_oe(alo),
        .addr_seg_oe(sgo), .ale(ale), .ale_oe(ale_oe), .rd_n(rd_n),
        .ctl_oe(cto), .low_byte_store_strobe_n(wr_lo_n),
        .high_byte_store_strobe_n(wr_hi_n), .high_strobe_oe(hso),
        .cs_n(cs_n), .cs_oe(cs_oe), .bus_grant_ack_n(),
        .bus_grant_ack_oe(gro), .bus_claim_n(), .bus_claim_oe(clo),
        .follower_mode(fol));
    ebpt_mem_model u_ebpt_mem_model (.clk_sys(clk_sys), .rd_n(rd_n),
        .cs_n(cs_n), .ad_out(ad_out), .ad_lo_oe(ad_oe), .ready_pol(rpol),
        .wait_cyc(wait_cyc), .ad_in(ad_in), .ready_in(ready));

    always #2 clk_sys = ~clk_sys;
    // reference clock offset so its edges never meet clk_sys edges
    initial begin
        #1.3;
        forever #80 ref_clk = ~ref_clk;
    end

    always @(posedge clk_sys) begin
        cyc_cnt <= cyc_cnt + 1;
        if (!wr_lo_n) begin
            lo_seen <= 1;
            a0 <= addr_out[0];
        end
        if (!wr_hi_n) hi_seen <= 1;
        if (ale && ad_oe) lat_ad <= ad_out;
        if (!rd_n) rd_len <= rd_len + 1;
        if (ale) ale_len <= ale_len + 1;
        if (!wr_lo_n) lo_len <= lo_len + 1;
        // counted only while selected, so the task's clear never races
        if (cs_n != 8'hFF) begin
            cs_len <= cs_len + 1;
            cs_and <= cs_and & cs_n;
        end
        if (cyc_cnt == 60000) begin
            num_errors++;
            summarize();
        end
    end

    task summarize;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = rdat;
        cyc <= 0;
        stb <= 0;
    endtask

    // one bus access, then wait for busy to rise and fall again
    task access(input logic w, input logic lo, input logic hi);
        lo_seen = 0;
        hi_seen = 0;
        rd_len = 0;
        ale_len = 0;
        lo_len = 0;
        cs_len = 0;
        cs_and = 8'hFF;
        wb(1, 8'h08, 32'h0000_1234);
        wb(1, 8'h0C, 32'h0000_BEEF);
        wb(1, 8'h10, {28'h000_0000, hi, lo, w, 1'b1});
        for (int i = 0; i < 200 && q[0] !== 1'b1; i++) wb(0, 8'h14, 32'h0);
        for (int i = 0; i < 200 && q[0] !== 1'b0; i++) wb(0, 8'h14, 32'h0);
        check(q[0], 1'b0);
    endtask

    task t_regs;
        wb(0, 8'h00, 32'h0);
        check(q, 32'h0000_0000);
        wb(1, 8'h04, 32'h0000_FFFF);
        wb(0, 8'h04, 32'h0);
        check(q, 32'h0000_005F);
        check(alo, 1'b0);
        wb(0, 8'h18, 32'h0);
        check(q, 32'h0000_0000);
        wb(1, 8'h04, 32'h0000_0000);
        wb(1, 8'h00, 32'h0000_3388);
        repeat (2) @(posedge clk_sys);
        check({ale_oe, cs_oe}, {1'b0, 8'hFF});
        check({hso, cto, clo, gro, fol}, 5'b01101);
        check({alo, sgo}, 9'h1FF);
        wb(1, 8'h00, 32'h0000_3399);
        repeat (2) @(posedge clk_sys);
        check({cs_oe, sgo}, 16'hFFFF);
        $display("registers done");
    endtask

    task t_strobes;
        logic [1:0] want;
        for (int s = 0; s < 2; s++) begin
            wb(1, 8'h00, s ? 32'h0000_0888 : 32'h0000_0088);
            for (int k = 1; k < 4; k++) begin
                access(1, k[0], k[1]);
                want = s ? {k[0], k[1]} : {1'b1, k[1]};
                check({lo_seen, hi_seen}, want);
                if (s == 0) check(a0, k[1] & ~k[0]);
            end
        end
        $display("strobes done");
    endtask

    // each tick is exactly 40 system clocks, so lengths are 40 times the tick counts
    task t_phases;
        // select 0: turnaround 3, latch 2, delay 1, data 1, command 2, hold 1
        tim[0] <= 15'h206F;
        access(1, 1, 1);
        check(ale_len, 80);
        check(cs_len, 280);
        check(lo_len, 80);
        check(cs_and, 8'hFE);
        // two idle ticks cut the turnaround of select 0 from 3 to 1
        hit <= 7'h01;
        repeat (80) @(posedge clk_sys);
        access(1, 1, 1);
        check(ale_len, 80);
        check(cs_len, 120);
        check(cs_and, 8'hFD);
        hit <= 7'h00;
        tim <= '0;
        $display("phases done");
    endtask

    task t_read;
        btyp[0] <= 2'b01;
        wb(1, 8'h00, 32'h0000_0088);
        access(0, 0, 0);
        check(q[31:16], 16'hA5C3);
        check(lat_ad, 16'h1234);
        rdy_en[0] <= 1'b1;
        wait_cyc <= 16'h00C8;
        rpol <= 1'b1;
        wb(1, 8'h00, 32'h0000_8088);
        access(0, 0, 0);
        check(q[31:16], 16'hA50B);
        check(rd_len >= 200, 1'b1);
        $display("reads done");
    endtask

    task t_lock;
        @(posedge clk_sys);
        lock <= 1;
        @(posedge clk_sys);
        lock <= 0;
        wb(1, 8'h00, 32'h0000_1234);
        wb(0, 8'h00, 32'h0);
        check(q, 32'h0000_8088);
        $display("lock done");
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        srst <= 0;
        t_regs();
        t_strobes();
        t_phases();
        t_read();
        t_lock();
        summarize();
    end
endmodule
